/* File: sdhic_card_model.sv */
// sdhic_card_model: card side of the host, makes bursts of card clock
// assumes the bench raises i_go once per burst and waits for it to end
`timescale 1ns/1ns
module sdhic_card_model
(
  input  wire logic       i_go,
  input  wire logic [3:0] i_halves,
  output logic            o_card_clk,
  output logic            o_hs_ok
);
  // ****************************************
  // card behaviour
  // ****************************************
  // card reports high speed support in its own registers
  assign o_hs_ok = 1'b1;
  // half periods of 32 ns; the clock stands still between bursts
  initial o_card_clk = 1'b0;
  always @(posedge i_go)
  begin
    repeat (i_halves)
    begin
      #32;
      o_card_clk = ~o_card_clk;
    end
  end
endmodule : sdhic_card_model

/* File: sdhic_pkg.sv */
// sdhic_pkg: constants and carriers for the card host irq/dma/config bank
// assumes one bus clock; all offsets are full byte addresses
package sdhic_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] ADDR_STATUS  = 32'hfff8_0040;
  localparam logic [31:0] ADDR_IRQ_SET = 32'hfff8_0044;
  localparam logic [31:0] ADDR_IRQ_CLR = 32'hfff8_0048;
  localparam logic [31:0] ADDR_IRQ_ST  = 32'hfff8_004c;
  localparam logic [31:0] ADDR_DMA_CFG = 32'hfff8_0050;
  localparam logic [31:0] ADDR_HOST_CF = 32'hfff8_0054;
  localparam logic [31:0] ADDR_LOCK    = 32'hfff8_00e4;
  // ****************************************
  // field positions and values
  // ****************************************
  localparam int          POS_UNDERRUN = 31;
  localparam int          POS_OVERRUN  = 30;
  localparam int          POS_OFFSET   = 0;
  localparam int          POS_CHUNK    = 4;
  localparam int          POS_HS_EN    = 8;
  localparam int          POS_PAD      = 12;
  localparam int          POS_WSTART   = 0;
  localparam int          POS_FECLR    = 4;
  localparam int          POS_FAST     = 8;
  localparam int          POS_LAST_BLOCK_SYNC    = 12;
  localparam int          POS_LOCK_EN  = 0;
  localparam int          POS_KEY      = 8;
  localparam logic [23:0] LOCK_KEY     = 24'h4d_4349;
  localparam logic [31:0] RST_MASK     = 32'h0000_0000;
  localparam logic [15:0] FIFO_BYTES   = 16'h0400;
  localparam logic [15:0] FIFO_HALF    = 16'h0200;
  localparam logic [15:0] FIFO_QUART   = 16'h0100;
  localparam logic [15:0] FIFO_3QUART  = 16'h0300;
  localparam logic [15:0] ONE_ITEM     = 16'h0001;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        pad;
    logic        hs_en;
    logic [1:0]  chunk;
    logic [1:0]  offset;
  } sdhic_dma_t;
  typedef struct packed {
    logic        last_block_sync;
    logic        fast;
    logic        feclr;
    logic        wstart;
  } sdhic_host_t;
  typedef struct packed {
    logic [31:0] mask;
    sdhic_dma_t  dma;
    sdhic_host_t host;
    logic        lock;
    logic        tx_underrun_flag;
    logic        rx_overrun_flag;
    logic [31:0] rdata;
    logic        irq;
    logic        dma_req;
    logic        first_pend;
    logic [3:0]  be;
    logic        wr_go;
    logic        cmd_issue;
    logic [2:0]  cclk;
    logic        launch;
    logic [15:0] rd_len;
    logic        two_desc;
  } sdhic_state_t;
endpackage : sdhic_pkg

/* File: sdhic_top.sv */
// sdhic_top: interrupt mask, flow error flags, dma handshake and host config
// assumes datapath strobes share I_CLOCK; card clock arrives asynchronously
//
// Contract
// - set underrun when a byte goes out with no valid data written
// - clear underrun on new transfer command or clear-select written one
// - with clear-select one, status read clears underrun
// - enable-set write ones set mask bits, zeros keep them
// - enable-clear write ones clear mask bits, zeros keep them
// - mask read returns enabled sources at status bit positions
// - dma and host config writes ignored while write lock enabled
// - first dma word drops the offset count of leading bytes
// - dma request only when chunk items available: 1, 4, 8, 16
// - dma handshake only while handshake enable is one
// - no padding moves exact block length, two descriptors if unaligned
// - padding moves block length rounded up to four bytes
// - policy zero: half fifo at 3/4 length, quarter at half length
// - policy zero, short block: start after whole block is in fifo
// - policy one: start once one item is in fifo
// - clear-select zero: flow flags clear only on new command
// - clear-select one: status read clears flow flags
// - fast timing launches lines on rising card clock, else default
// - last-block sync zero: pending command at end of block
// - sync one: hold command to transfer end; block count nonzero
// - set overrun on lost byte, clear on new transfer command
// - lock changes only when the write key matches
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
module sdhic_top
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_SYS_RST,
  input  wire logic [31:0] I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [29:0] I_SRC_STATUS,
  input  wire logic        I_TX_BYTE_SENT,
  input  wire logic        I_TX_DATA_VALID,
  input  wire logic        I_RX_BYTE_LOST,
  input  wire logic        I_NEW_XFER_CMD,
  input  wire logic [15:0] I_FIFO_LEVEL,
  input  wire logic [15:0] I_BLOCK_LENGTH,
  input  wire logic        I_DMA_WR,
  input  wire logic        I_CMD_PENDING,
  input  wire logic        I_BLOCK_END,
  input  wire logic        I_XFER_END,
  input  wire logic        I_CARD_CLK,
  output logic      [31:0] O_RDATA,
  output logic             O_IRQ,
  output logic             O_DMA_REQ,
  output logic       [3:0] O_DMA_BE,
  output logic             O_WRITE_GO,
  output logic             O_CMD_ISSUE,
  output logic             O_LINE_LAUNCH,
  output logic      [15:0] O_READ_MOVE_LEN,
  output logic             O_TWO_DESC
);

  // ****************************************
  // helpers
  // ****************************************
  // chunk encoding to item count, shared by logic and checks
  function automatic logic [15:0] chunk_items(input logic [1:0] code);
    case (code)
      2'b00:   chunk_items = 16'h0001;
      2'b01:   chunk_items = 16'h0004;
      2'b10:   chunk_items = 16'h0008;
      default: chunk_items = 16'h0010;
    endcase
  endfunction : chunk_items

  sdhic_pkg::sdhic_state_t s_r;
  sdhic_pkg::sdhic_state_t s_nxt;
  logic [31:0] status;
  logic        wr_cfg_ok;
  logic        stat_rd;
  logic        ur_evt;
  logic        fe_wr_one;
  logic [15:0] start_need;
  logic        cclk_rise;
  logic        cclk_fall;

  // ****************************************
  // decode
  // ****************************************
  // flags sit above the datapath's own status bits
  assign status    = {s_r.tx_underrun_flag, s_r.rx_overrun_flag, I_SRC_STATUS};
  assign wr_cfg_ok = I_WR && !s_r.lock;
  assign stat_rd   = I_RD && (I_ADDR == sdhic_pkg::ADDR_STATUS);
  assign ur_evt    = I_TX_BYTE_SENT && !I_TX_DATA_VALID;
  assign fe_wr_one = wr_cfg_ok && (I_ADDR == sdhic_pkg::ADDR_HOST_CF)
                     && I_WDATA[sdhic_pkg::POS_FECLR];
  // card clock edges are seen only after both sync stages
  assign cclk_rise = s_r.cclk[1] && !s_r.cclk[2];
  assign cclk_fall = !s_r.cclk[1] && s_r.cclk[2];

  // write start threshold; with policy zero a short block must be wholly loaded first
  always_comb
  begin
    if (s_r.host.wstart)
      start_need = sdhic_pkg::ONE_ITEM;
    else if (I_BLOCK_LENGTH >= sdhic_pkg::FIFO_3QUART)
      start_need = sdhic_pkg::FIFO_HALF;
    else if (I_BLOCK_LENGTH >= sdhic_pkg::FIFO_HALF)
      start_need = sdhic_pkg::FIFO_QUART;
    else
      start_need = I_BLOCK_LENGTH;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_nxt = s_r;
    // register writes
    if (I_WR)
    begin
      case (I_ADDR)
        sdhic_pkg::ADDR_IRQ_SET: s_nxt.mask = s_r.mask | I_WDATA;
        sdhic_pkg::ADDR_IRQ_CLR: s_nxt.mask = s_r.mask & ~I_WDATA;
        sdhic_pkg::ADDR_DMA_CFG:
        begin
          if (wr_cfg_ok)
          begin
            s_nxt.dma.offset = I_WDATA[sdhic_pkg::POS_OFFSET +: 2];
            s_nxt.dma.chunk  = I_WDATA[sdhic_pkg::POS_CHUNK +: 2];
            s_nxt.dma.hs_en  = I_WDATA[sdhic_pkg::POS_HS_EN];
            s_nxt.dma.pad    = I_WDATA[sdhic_pkg::POS_PAD];
          end
        end
        sdhic_pkg::ADDR_HOST_CF:
        begin
          if (wr_cfg_ok)
          begin
            s_nxt.host.wstart = I_WDATA[sdhic_pkg::POS_WSTART];
            s_nxt.host.feclr  = I_WDATA[sdhic_pkg::POS_FECLR];
            s_nxt.host.fast   = I_WDATA[sdhic_pkg::POS_FAST];
            s_nxt.host.last_block_sync  = I_WDATA[sdhic_pkg::POS_LAST_BLOCK_SYNC];
          end
        end
        sdhic_pkg::ADDR_LOCK:
        begin
          if (I_WDATA[31:sdhic_pkg::POS_KEY] == sdhic_pkg::LOCK_KEY)
            s_nxt.lock = I_WDATA[sdhic_pkg::POS_LOCK_EN];
        end
        default: ;
      endcase
    end
    // read data answers one cycle later; unmapped reads give zero
    s_nxt.rdata = 32'h0000_0000;
    if (I_RD)
    begin
      case (I_ADDR)
        sdhic_pkg::ADDR_STATUS:  s_nxt.rdata = status;
        sdhic_pkg::ADDR_IRQ_ST:  s_nxt.rdata = s_r.mask;
        sdhic_pkg::ADDR_DMA_CFG:
          s_nxt.rdata = 32'(s_r.dma.offset) << sdhic_pkg::POS_OFFSET
                      | 32'(s_r.dma.chunk) << sdhic_pkg::POS_CHUNK
                      | 32'(s_r.dma.hs_en) << sdhic_pkg::POS_HS_EN
                      | 32'(s_r.dma.pad) << sdhic_pkg::POS_PAD;
        sdhic_pkg::ADDR_HOST_CF:
          s_nxt.rdata = 32'(s_r.host.wstart) << sdhic_pkg::POS_WSTART
                      | 32'(s_r.host.feclr) << sdhic_pkg::POS_FECLR
                      | 32'(s_r.host.fast) << sdhic_pkg::POS_FAST
                      | 32'(s_r.host.last_block_sync) << sdhic_pkg::POS_LAST_BLOCK_SYNC;
        sdhic_pkg::ADDR_LOCK:
          s_nxt.rdata = 32'(s_r.lock) << sdhic_pkg::POS_LOCK_EN;
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // flow flags: clears first, so a same-cycle event still sets
    if (I_NEW_XFER_CMD)
    begin
      s_nxt.tx_underrun_flag = 1'b0;
      s_nxt.rx_overrun_flag = 1'b0;
    end
    if (fe_wr_one)
      s_nxt.tx_underrun_flag = 1'b0;
    if (stat_rd && s_r.host.feclr)
    begin
      s_nxt.tx_underrun_flag = 1'b0;
      s_nxt.rx_overrun_flag = 1'b0;
    end
    if (ur_evt)
      s_nxt.tx_underrun_flag = 1'b1;
    if (I_RX_BYTE_LOST)
      s_nxt.rx_overrun_flag = 1'b1;
    // interrupt line from the current status bits (sources and flags) and mask
    s_nxt.irq = |(status & s_r.mask);
    // dma handshake stays quiet while disabled
    s_nxt.dma_req = s_r.dma.hs_en
                    && (I_FIFO_LEVEL >= chunk_items(s_r.dma.chunk));
    // leading-byte drop applies to the first dma word only
    if (I_NEW_XFER_CMD)
      s_nxt.first_pend = 1'b1;
    else if (I_DMA_WR && s_r.dma.hs_en)
      s_nxt.first_pend = 1'b0;
    s_nxt.be = s_nxt.first_pend ? (4'hf << s_r.dma.offset) : 4'hf;
    // card write start threshold
    s_nxt.wr_go = (I_FIFO_LEVEL >= start_need)
                  && (I_FIFO_LEVEL != 16'h0000);
    // pending command released on block end or whole transfer end
    s_nxt.cmd_issue = I_CMD_PENDING
                      && (s_r.host.last_block_sync ? I_XFER_END : I_BLOCK_END);
    // card clock: two sync stages plus a history bit for edges
    s_nxt.cclk = {s_r.cclk[1:0], I_CARD_CLK};
    s_nxt.launch = s_r.host.fast ? cclk_rise : cclk_fall;
    // read length: exact or rounded up to whole words
    if (s_r.dma.pad)
      s_nxt.rd_len = (I_BLOCK_LENGTH + 16'h0003) & 16'hfffc;
    else
      s_nxt.rd_len = I_BLOCK_LENGTH;
    s_nxt.two_desc = !s_r.dma.pad && (I_BLOCK_LENGTH[1:0] != 2'b00);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      s_r      <= '0;
      s_r.mask <= sdhic_pkg::RST_MASK;
      s_r.be   <= 4'hf;
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from flops
  assign O_RDATA         = s_r.rdata;
  assign O_IRQ           = s_r.irq;
  assign O_DMA_REQ       = s_r.dma_req;
  assign O_DMA_BE        = s_r.be;
  assign O_WRITE_GO      = s_r.wr_go;
  assign O_CMD_ISSUE     = s_r.cmd_issue;
  assign O_LINE_LAUNCH   = s_r.launch;
  assign O_READ_MOVE_LEN = s_r.rd_len;
  assign O_TWO_DESC      = s_r.two_desc;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);

  underrun_set_a: assert property (ur_evt |=> s_r.tx_underrun_flag)
    else $error("underrun not set");
  underrun_wclr_a: assert property (fe_wr_one && !ur_evt |=> !s_r.tx_underrun_flag)
    else $error("underrun not cleared by clear-select write");
  flow_rdclr_a: assert property (stat_rd && s_r.host.feclr && !ur_evt
      && !I_RX_BYTE_LOST |=> !s_r.tx_underrun_flag && !s_r.rx_overrun_flag)
    else $error("flow flags not cleared by status read");
  flow_keep_a: assert property (stat_rd && !s_r.host.feclr && s_r.rx_overrun_flag
      && !I_NEW_XFER_CMD |=> s_r.rx_overrun_flag)
    else $error("overrun cleared without command");
  mask_set_a: assert property (I_WR && I_ADDR == sdhic_pkg::ADDR_IRQ_SET
      |=> (s_r.mask & $past(I_WDATA)) == $past(I_WDATA)
          && (s_r.mask & $past(s_r.mask)) == $past(s_r.mask))
    else $error("mask set wrong");
  mask_clr_a: assert property (I_WR && I_ADDR == sdhic_pkg::ADDR_IRQ_CLR
      |=> s_r.mask == ($past(s_r.mask) & ~$past(I_WDATA)))
    else $error("mask clear wrong");
  mask_read_a: assert property (I_RD && I_ADDR == sdhic_pkg::ADDR_IRQ_ST
      |=> O_RDATA == $past(s_r.mask))
    else $error("mask readback wrong");
  irq_level_a: assert property (O_IRQ == $past(|(status & s_r.mask)))
    else $error("irq level wrong");
  lock_hold_a: assert property (s_r.lock && I_WR
      && I_ADDR == sdhic_pkg::ADDR_HOST_CF |=> $stable(s_r.host))
    else $error("locked config changed");
  dma_req_a: assert property (O_DMA_REQ |-> $past(s_r.dma.hs_en)
      && $past(I_FIFO_LEVEL) >= chunk_items($past(s_r.dma.chunk)))
    else $error("dma request without data or enable");
  lock_key_a: assert property (I_WR && I_ADDR == sdhic_pkg::ADDR_LOCK
      && I_WDATA[31:8] != sdhic_pkg::LOCK_KEY |=> $stable(s_r.lock))
    else $error("lock changed with bad key");
  cmd_sync_a: assert property (O_CMD_ISSUE && $past(s_r.host.last_block_sync)
      |-> $past(I_XFER_END))
    else $error("command issued before transfer end");
  pad_len_a: assert property (s_r.dma.pad ##1 s_r.dma.pad
      |-> O_READ_MOVE_LEN[1:0] == 2'b00)
    else $error("padded length not word multiple");

endmodule : sdhic_top

/* File: test_sdhic_top.sv */
// test_sdhic_top: register-level tests of the irq, dma and config bank
// assumes sdhic_pkg and sdhic_card_model are compiled first
`timescale 1ns/1ns
module test_sdhic_top;
  // ****************************************
  // signals and tasks
  // ****************************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] addr = '0;
  logic [31:0] wdata = '0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [29:0] src = '0;
  logic        valid = 1'b1;
  logic [5:0]  ev = '0;  // sent, lost, new cmd, dma wr, block end, xfer end
  logic [15:0] lvl = '0;
  logic [15:0] blen = '0;
  logic        pend = 1'b0;
  logic        go = 1'b0;
  logic        card_clk, hs_ok, irq, dreq, wgo, issue, launch, two;
  logic [31:0] rdata;
  logic [3:0]  be, expbe;
  logic [15:0] mlen;
  int          bad_count = 0, checked = 0, launches = 0, issues = 0, n;
  logic [33:0] wtab [8] = '{
    {1'b0, 16'h0300, 16'h01ff, 1'b0}, {1'b0, 16'h0300, 16'h0200, 1'b1},
    {1'b0, 16'h02ff, 16'h00ff, 1'b0}, {1'b0, 16'h02ff, 16'h0100, 1'b1},
    {1'b0, 16'h01ff, 16'h01fe, 1'b0}, {1'b0, 16'h01ff, 16'h01ff, 1'b1},
    {1'b1, 16'h01ff, 16'h0000, 1'b0}, {1'b1, 16'h01ff, 16'h0001, 1'b1}};
  always #4 clk = ~clk;
  // pulses are counted so that their exact cycle does not matter
  always @(posedge clk)
  begin
    if (launch === 1'b1) launches <= launches + 1;
    if (issue === 1'b1) issues <= issues + 1;
  end
  sdhic_card_model card (.i_go(go), .i_halves(4'h5), .o_card_clk(card_clk), .o_hs_ok(hs_ok));
  sdhic_top uut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .I_SRC_STATUS(src), .I_TX_BYTE_SENT(ev[0]), .I_TX_DATA_VALID(valid),
    .I_RX_BYTE_LOST(ev[1]), .I_NEW_XFER_CMD(ev[2]), .I_FIFO_LEVEL(lvl),
    .I_BLOCK_LENGTH(blen), .I_DMA_WR(ev[3]), .I_CMD_PENDING(pend), .I_BLOCK_END(ev[4]),
    .I_XFER_END(ev[5]), .I_CARD_CLK(card_clk), .O_RDATA(rdata), .O_IRQ(irq),
    .O_DMA_REQ(dreq), .O_DMA_BE(be), .O_WRITE_GO(wgo), .O_CMD_ISSUE(issue),
    .O_LINE_LAUNCH(launch), .O_READ_MOVE_LEN(mlen), .O_TWO_DESC(two));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe, held with address and data
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_reg
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask : pulse
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  // ****************************************
  // tests
  // ****************************************
  // a hang is cut short well past the expected run of about 300 cycles
  initial
  begin
    repeat (8000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(sdhic_pkg::ADDR_IRQ_ST, sdhic_pkg::RST_MASK);
    wr_reg(sdhic_pkg::ADDR_IRQ_SET, 32'hc000_0001);
    wr_reg(sdhic_pkg::ADDR_IRQ_CLR, 32'h4000_0000);
    wr_reg(sdhic_pkg::ADDR_IRQ_SET, 32'h0000_0002);
    rd_reg(sdhic_pkg::ADDR_IRQ_ST, 32'h8000_0003);
    rd_reg(sdhic_pkg::ADDR_IRQ_SET, 32'h0000_0000);
    rd_reg(32'hfff8_0060, 32'h0000_0000);
    // unmasked source must not interrupt, masked one must
    @(posedge clk) src <= 30'h0000_0004;
    step(3);
    chk(irq, 1'b0);
    @(posedge clk) src <= 30'h0000_0002;
    step(3);
    chk(irq, 1'b1);
    @(posedge clk) src <= '0;
    // flow error flags with clear-select zero, then one
    pulse(6'h01);
    rd_reg(sdhic_pkg::ADDR_STATUS, 32'h0000_0000);
    @(posedge clk) valid <= 1'b0;
    pulse(6'h01);
    rd_reg(sdhic_pkg::ADDR_STATUS, 32'h8000_0000);
    chk(irq, 1'b1);
    rd_reg(sdhic_pkg::ADDR_STATUS, 32'h8000_0000);
    pulse(6'h02);
    rd_reg(sdhic_pkg::ADDR_STATUS, 32'hc000_0000);
    pulse(6'h04);
    rd_reg(sdhic_pkg::ADDR_STATUS, 32'h0000_0000);
    pulse(6'h03);
    wr_reg(sdhic_pkg::ADDR_HOST_CF, 32'h0000_0010);
    rd_reg(sdhic_pkg::ADDR_STATUS, 32'h4000_0000);
    rd_reg(sdhic_pkg::ADDR_STATUS, 32'h0000_0000);
    pulse(6'h01);
    rd_reg(sdhic_pkg::ADDR_STATUS, 32'h8000_0000);
    rd_reg(sdhic_pkg::ADDR_STATUS, 32'h0000_0000);
    valid <= 1'b1;
    // chunk request thresholds 1, 4, 8 and 16
    for (int c = 0; c < 4; c++)
    begin
      n = (c == 0) ? 1 : (1 << (c + 1));
      wr_reg(sdhic_pkg::ADDR_DMA_CFG, 32'h0000_0100 | (c << 4));
      @(posedge clk) lvl <= 16'(n - 1);
      step(3);
      chk(dreq, 1'b0);
      @(posedge clk) lvl <= 16'(n);
      step(3);
      chk(dreq, 1'b1);
    end
    // handshake off, then first-word byte enables for each offset
    wr_reg(sdhic_pkg::ADDR_DMA_CFG, 32'h0000_0030);
    step(3);
    chk(dreq, 1'b0);
    for (int o = 0; o < 4; o++)
    begin
      wr_reg(sdhic_pkg::ADDR_DMA_CFG, 32'h0000_0100 | o);
      pulse(6'h04);
      step(1);
      expbe = 4'hf << o;
      chk(32'(be), 32'(expbe));
    end
    pulse(6'h08);
    step(1);
    chk(32'(be), 32'h0000_000f);
    // read length with and without padding
    @(posedge clk) blen <= 16'h000d;
    wr_reg(sdhic_pkg::ADDR_DMA_CFG, 32'h0000_0000);
    step(2);
    chk(32'(mlen), 32'h0000_000d);
    chk(two, 1'b1);
    wr_reg(sdhic_pkg::ADDR_DMA_CFG, 32'h0000_1000);
    step(2);
    chk(32'(mlen), 32'h0000_0010);
    chk(two, 1'b0);
    // write start points at each boundary
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(sdhic_pkg::ADDR_HOST_CF, 32'(wtab[i][33]));
      @(posedge clk);
      blen <= wtab[i][32:17];
      lvl <= wtab[i][16:1];
      step(3);
      chk(wgo, wtab[i][0]);
    end
    // pending command release, bench keeps a finite block count
    @(posedge clk) pend <= 1'b1;
    wr_reg(sdhic_pkg::ADDR_HOST_CF, 32'h0000_0000);
    n = issues;
    pulse(6'h20);
    step(2);
    chk(issues - n, 0);
    pulse(6'h10);
    step(2);
    chk(issues - n, 1);
    wr_reg(sdhic_pkg::ADDR_HOST_CF, 32'h0000_1000);
    pulse(6'h10);
    step(2);
    chk(issues - n, 1);
    pulse(6'h20);
    step(2);
    chk(issues - n, 2);
    pend <= 1'b0;
    // five half periods from low: two falls; then from high: two rises
    wr_reg(sdhic_pkg::ADDR_HOST_CF, 32'h0000_0000);
    n = launches;
    go <= 1'b1;
    step(30);
    chk(launches - n, 2);
    go <= 1'b0;
    if (hs_ok) wr_reg(sdhic_pkg::ADDR_HOST_CF, 32'h0000_0100);
    n = launches;
    go <= 1'b1;
    step(30);
    chk(launches - n, 2);
    // write lock with a wrong and a right key
    wr_reg(sdhic_pkg::ADDR_LOCK, 32'h4d43_4801);
    wr_reg(sdhic_pkg::ADDR_DMA_CFG, 32'h0000_1000);
    rd_reg(sdhic_pkg::ADDR_DMA_CFG, 32'h0000_1000);
    wr_reg(sdhic_pkg::ADDR_LOCK, 32'h4d43_4901);
    wr_reg(sdhic_pkg::ADDR_DMA_CFG, 32'h0000_0000);
    wr_reg(sdhic_pkg::ADDR_HOST_CF, 32'h0000_1111);
    rd_reg(sdhic_pkg::ADDR_DMA_CFG, 32'h0000_1000);
    rd_reg(sdhic_pkg::ADDR_HOST_CF, 32'h0000_0100);
    wr_reg(sdhic_pkg::ADDR_LOCK, 32'h4d43_4900);
    wr_reg(sdhic_pkg::ADDR_DMA_CFG, 32'h0000_0000);
    rd_reg(sdhic_pkg::ADDR_DMA_CFG, 32'h0000_0000);
    print_verdict;
  end
endmodule : test_sdhic_top
